// ==== logic/eesf_top.sv ====
// encoder event status flags with position counter, homing and register port
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "eesf_regs.svh"

module eesf_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire eesf_pkg::eesf_bus_req_s i_bus,
  output logic [15:0] o_rdata,
  // count steps from the quadrature decoder
  input wire logic i_count_up,
  input wire logic i_count_down,
  // encoder pins
  input wire logic i_home,
  input wire logic i_index,
  // interrupt and state
  output logic o_irq,
  output logic [31:0] o_position_count
);

  import eesf_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  eesf_event_t flags;
  eesf_event_t enables;
  eesf_event_t mask;
  eesf_event_t ev_set;
  eesf_event_t ev_clr;
  eesf_position_init_mode_e position_init_mode;
  eesf_home_e home_state;
  eesf_home_e next_home_state;
  logic [15:0] position_high_hold;
  logic [31:0] init_capture_value;
  logic [31:0] upper_compare_value;
  logic [31:0] lower_compare_value;
  logic [31:0] position_count;
  logic [15:0] velocity_count;
  logic [31:0] next_position_load;
  logic position_load;
  logic homing_load;
  logic position_overflow;
  logic velocity_overflow;
  logic velocity_load;
  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic home_rise;
  logic index_rise;
  logic homing_mode;
  logic [15:0] status_word;
  logic [15:0] next_rdata;
  logic wr_stat;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  eesf_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin({i_index, i_home}),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  assign home_rise = pin_rise[0];
  assign index_rise = pin_rise[1];

  // ----------------------------------------
  // position and velocity counters
  // ----------------------------------------
  eesf_counter #(
    .WIDTH(32)
  ) u_position (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_up(i_count_up),
    .i_down(i_count_down),
    .i_load(position_load),
    .i_load_value(next_position_load),
    .o_count(position_count),
    .o_overflow(position_overflow)
  );

  // velocity counts the same steps as position
  eesf_counter #(
    .WIDTH(16)
  ) u_velocity (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_up(i_count_up),
    .i_down(i_count_down),
    .i_load(velocity_load),
    .i_load_value(i_bus.wdata),
    .o_count(velocity_count),
    .o_overflow(velocity_overflow)
  );

  assign velocity_load = i_bus.wr && hit(i_bus.addr, `EESF_OFS_VEL);

  // ----------------------------------------
  // position load sources
  // ----------------------------------------
  // software write wins over a homing reload in the same cycle
  always_comb
  begin
    position_load = 1'b1;
    next_position_load = position_count;
    if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_POSL))
      next_position_load = {position_high_hold, i_bus.wdata};
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_POSH))
      next_position_load = {i_bus.wdata, position_count[15:0]};
    else if (homing_load)
      next_position_load = init_capture_value;
    else
      position_load = 1'b0;
  end

  // ----------------------------------------
  // high word hold register
  // ----------------------------------------
  // reading the low word freezes the high word so a pair of reads is coherent
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      position_high_hold <= `EESF_RST_WORD;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_HOLD))
      position_high_hold <= i_bus.wdata;
    else if (i_bus.rd && hit(i_bus.addr, `EESF_OFS_POSL))
      position_high_hold <= position_count[31:16];
  end

  // ----------------------------------------
  // init mode and compare values
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      position_init_mode <= EESF_POSITION_INIT_MODE_NONE;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_CTRL))
      position_init_mode <= eesf_position_init_mode_e'(i_bus.wdata[2:0]);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      init_capture_value <= `EESF_RST_LONG;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_INITL))
      init_capture_value[15:0] <= i_bus.wdata;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_INITH))
      init_capture_value[31:16] <= i_bus.wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      upper_compare_value <= `EESF_RST_LONG;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_GECL))
      upper_compare_value[15:0] <= i_bus.wdata;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_GECH))
      upper_compare_value[31:16] <= i_bus.wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      lower_compare_value <= `EESF_RST_LONG;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_LECL))
      lower_compare_value[15:0] <= i_bus.wdata;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_LECH))
      lower_compare_value[31:16] <= i_bus.wdata;
  end

  // ----------------------------------------
  // homing sequence
  // ----------------------------------------
  assign homing_mode = (position_init_mode == EESF_POSITION_INIT_MODE_HOME_IDX1) ||
                       (position_init_mode == EESF_POSITION_INIT_MODE_HOME_IDX2);

  // a fresh home event rearms the sequence at any point
  always_comb
  begin
    next_home_state = home_state;
    homing_load = 1'b0;
    case (home_state)
      EESF_HM_IDLE:
      begin
        if (homing_mode)
          next_home_state = EESF_HM_WAIT_HOME;
      end
      EESF_HM_WAIT_HOME:
      begin
        if (home_rise)
          next_home_state = EESF_HM_WAIT_IDX1;
      end
      EESF_HM_WAIT_IDX1:
      begin
        if (home_rise)
          next_home_state = EESF_HM_WAIT_IDX1;
        else if (index_rise && position_init_mode == EESF_POSITION_INIT_MODE_HOME_IDX1)
        begin
          homing_load = 1'b1;
          next_home_state = EESF_HM_WAIT_HOME;
        end
        else if (index_rise)
          next_home_state = EESF_HM_WAIT_IDX2;
      end
      EESF_HM_WAIT_IDX2:
      begin
        if (home_rise)
          next_home_state = EESF_HM_WAIT_IDX1;
        else if (index_rise)
        begin
          homing_load = 1'b1;
          next_home_state = EESF_HM_WAIT_HOME;
        end
      end
      default:
        next_home_state = EESF_HM_IDLE;
    endcase
    if (!homing_mode)
    begin
      next_home_state = EESF_HM_IDLE;
      homing_load = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      home_state <= EESF_HM_IDLE;
    else
      home_state <= next_home_state;
  end

  // ----------------------------------------
  // event sources
  // ----------------------------------------
  always_comb
  begin
    ev_set = '0;
    ev_set[`EESF_EV_UPPER] = $signed(position_count) >= $signed(upper_compare_value);
    ev_set[`EESF_EV_LOWER] = $signed(position_count) <= $signed(lower_compare_value);
    ev_set[`EESF_EV_POSOV] = position_overflow;
    ev_set[`EESF_EV_HOMING] = homing_load && homing_mode;
    ev_set[`EESF_EV_VELOV] = velocity_overflow;
    ev_set[`EESF_EV_HOME] = home_rise;
    ev_set[`EESF_EV_INDEX] = index_rise;
  end

  // ----------------------------------------
  // status register layout
  // ----------------------------------------
  assign wr_stat = i_bus.wr && hit(i_bus.addr, `EESF_OFS_STAT);

  // flag i at bit 2*i+1, its enable at bit 2*i
  genvar g;
  generate
    for (g = 0; g < `EESF_NUM_EVENTS; g++)
    begin : g_layout
      assign status_word[2*g+1] = flags[g];
      assign status_word[2*g] = enables[g];
      assign ev_clr[g] = wr_stat && i_bus.wdata[2*g+1];
    end
  endgenerate

  assign status_word[15:14] = 2'b00;

  // ----------------------------------------
  // sticky flags, enables, mask
  // ----------------------------------------
  // set beats a write-one clear in the same cycle so no event is lost
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      flags <= `EESF_RST_FLAGS;
    else
      flags <= (flags & ~ev_clr) | ev_set;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      enables <= `EESF_RST_ENABLES;
    else if (wr_stat)
    begin
      for (int i = 0; i < `EESF_NUM_EVENTS; i++)
        enables[i] <= i_bus.wdata[2*i];
    end
  end

  // extra gate beside the enables; opens fully after reset
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      mask <= `EESF_RST_MASK;
    else if (i_bus.wr && hit(i_bus.addr, `EESF_OFS_MASK))
      mask <= i_bus.wdata[6:0];
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_irq <= 1'b0;
    else
      o_irq <= |(flags & enables & mask);
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb
  begin
    next_rdata = 16'h0000;
    case (i_bus.addr)
      `EESF_OFS_STAT: next_rdata = status_word;
      `EESF_OFS_MASK: next_rdata = {9'h000, mask};
      `EESF_OFS_CTRL: next_rdata = {13'h0000, position_init_mode};
      `EESF_OFS_POSL: next_rdata = position_count[15:0];
      `EESF_OFS_POSH: next_rdata = position_count[31:16];
      `EESF_OFS_HOLD: next_rdata = position_high_hold;
      `EESF_OFS_INITL: next_rdata = init_capture_value[15:0];
      `EESF_OFS_INITH: next_rdata = init_capture_value[31:16];
      `EESF_OFS_GECL: next_rdata = upper_compare_value[15:0];
      `EESF_OFS_GECH: next_rdata = upper_compare_value[31:16];
      `EESF_OFS_LECL: next_rdata = lower_compare_value[15:0];
      `EESF_OFS_LECH: next_rdata = lower_compare_value[31:16];
      `EESF_OFS_VEL: next_rdata = velocity_count;
      default: next_rdata = 16'h0000;
    endcase
  end

  // data only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_rdata <= 16'h0000;
    else if (i_bus.rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= 16'h0000;
  end

  // ----------------------------------------
  // position out
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_position_count <= `EESF_RST_LONG;
    else
      o_position_count <= position_count;
  end

endmodule : eesf_top

`default_nettype wire

// ==== logic/eesf_regs.svh ====
// register offsets, field positions, reset values of the encoder event status block
`ifndef EESF_REGS_SVH
`define EESF_REGS_SVH

// ----------------------------------------
// register offsets (word index on the port)
// ----------------------------------------
`define EESF_OFS_STAT 4'h0
`define EESF_OFS_MASK 4'h1
`define EESF_OFS_CTRL 4'h2
`define EESF_OFS_POSL 4'h3
`define EESF_OFS_POSH 4'h4
`define EESF_OFS_HOLD 4'h5
`define EESF_OFS_INITL 4'h6
`define EESF_OFS_INITH 4'h7
`define EESF_OFS_GECL 4'h8
`define EESF_OFS_GECH 4'h9
`define EESF_OFS_LECL 4'hA
`define EESF_OFS_LECH 4'hB
`define EESF_OFS_VEL 4'hC

// ----------------------------------------
// event index; flag at bit 2*i+1, enable at bit 2*i
// ----------------------------------------
`define EESF_NUM_EVENTS 7
`define EESF_EV_INDEX 0
`define EESF_EV_HOME 1
`define EESF_EV_VELOV 2
`define EESF_EV_HOMING 3
`define EESF_EV_POSOV 4
`define EESF_EV_LOWER 5
`define EESF_EV_UPPER 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define EESF_RST_FLAGS 7'h00
`define EESF_RST_ENABLES 7'h00
`define EESF_RST_MASK 7'h7F
`define EESF_RST_WORD 16'h0000
`define EESF_RST_LONG 32'h0000_0000

`endif

// ==== logic/eesf_pkg.sv ====
// types shared by the encoder event status block
package eesf_pkg;

  // ----------------------------------------
  // register port request
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } eesf_bus_req_s;

  // ----------------------------------------
  // position initialization modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    EESF_POSITION_INIT_MODE_NONE = 3'b000,
    EESF_POSITION_INIT_MODE_EVERY_IDX = 3'b001,
    EESF_POSITION_INIT_MODE_NEXT_IDX = 3'b010,
    EESF_POSITION_INIT_MODE_HOME_IDX1 = 3'b011,
    EESF_POSITION_INIT_MODE_HOME_IDX2 = 3'b100
  } eesf_position_init_mode_e;

  // ----------------------------------------
  // homing sequence states
  // ----------------------------------------
  typedef enum logic [1:0] {
    EESF_HM_IDLE = 2'b00,
    EESF_HM_WAIT_HOME = 2'b01,
    EESF_HM_WAIT_IDX1 = 2'b10,
    EESF_HM_WAIT_IDX2 = 2'b11
  } eesf_home_e;

  typedef logic [6:0] eesf_event_t;

endpackage : eesf_pkg

// ==== logic/eesf_sync.sv ====
// two-flop synchroniser with rising edge detect for encoder pins
`timescale 1ns/1ps
`default_nettype none

module eesf_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // pins
  input wire logic [WIDTH-1:0] i_pin,
  // synchronised view
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] last;

  // first stage feeds only the second
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end
    else
    begin
      meta <= i_pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign o_level = sync;
  assign o_rise = sync & ~last;

endmodule : eesf_sync

`default_nettype wire

// ==== logic/eesf_counter.sv ====
// signed up/down counter with load and overflow pulse
`timescale 1ns/1ps
`default_nettype none

module eesf_counter #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // count steps
  input wire logic i_up,
  input wire logic i_down,
  // load
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  // state
  output logic [WIDTH-1:0] o_count,
  output logic o_overflow
);

  localparam logic [WIDTH-1:0] MAX_POS = {1'b0, {(WIDTH-1){1'b1}}};
  localparam logic [WIDTH-1:0] MAX_NEG = {1'b1, {(WIDTH-1){1'b0}}};
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  // load wins over a step in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_count <= '0;
    else if (i_load)
      o_count <= i_load_value;
    else if (i_up && !i_down)
      o_count <= o_count + ONE;
    else if (i_down && !i_up)
      o_count <= o_count - ONE;
  end

  // signed wrap in either direction
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_overflow <= 1'b0;
    else
      o_overflow <= !i_load && ((i_up && !i_down && o_count == MAX_POS) ||
                                (i_down && !i_up && o_count == MAX_NEG));
  end

endmodule : eesf_counter

`default_nettype wire

// ==== verif/eesf_top_properties.sv ====
// port assertions of the encoder event status block
`timescale 1ns/1ps
`default_nettype none
`include "eesf_regs.svh"

module eesf_top_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire eesf_pkg::eesf_bus_req_s i_bus,
  input wire logic [15:0] o_rdata,
  // encoder side
  input wire logic i_count_up,
  input wire logic i_count_down,
  input wire logic i_home,
  input wire logic i_index,
  // interrupt and state
  input wire logic o_irq,
  input wire logic [31:0] o_position_count
);
  import eesf_pkg::*;

  // ----
  // timing frame
  // ----
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // ----
  // assertions
  // ----
  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  resv_bits_a: assert property (i_bus.rd && i_bus.addr == `EESF_OFS_STAT |=> o_rdata[15:14] == 2'b00)
    else $error("status bits 15 and 14 read non zero");
  unmapped_a: assert property (i_bus.rd && i_bus.addr > `EESF_OFS_VEL |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  reset_vals_a: assert property ($fell(i_reset) |-> !o_irq && o_position_count == 32'h0000_0000)
    else $error("irq or position not cleared by reset");
  // a homing load in the same cycle would also break this, the bench keeps them apart
  pos_step_a: assert property (i_count_up && !i_count_down && !i_bus.wr
    |=> ##1 o_position_count == $past(o_position_count) + 32'h0000_0001)
    else $error("position did not step up by one");
  irq_off_a: assert property (i_bus.wr && i_bus.addr == `EESF_OFS_STAT &&
    (i_bus.wdata & 16'h1555) == 16'h0000 |=> ##1 !o_irq)
    else $error("irq high with all enables off");
  enable_rb_a: assert property ((i_bus.wr && i_bus.addr == `EESF_OFS_STAT) ##1 !i_bus.wr
    ##1 (i_bus.rd && i_bus.addr == `EESF_OFS_STAT)
    |=> (o_rdata & 16'h1555) == ($past(i_bus.wdata, 3) & 16'h1555))
    else $error("enable bits do not read back as written");
  pos_low_a: assert property (i_bus.rd && i_bus.addr == `EESF_OFS_POSL
    |=> o_rdata == o_position_count[15:0])
    else $error("low position word read wrong");
  hold_rb_a: assert property ((i_bus.rd && i_bus.addr == `EESF_OFS_POSL) ##1 (!i_bus.wr && !i_bus.rd)
    ##1 (i_bus.rd && i_bus.addr == `EESF_OFS_HOLD)
    |=> o_rdata == $past(o_position_count[31:16], 2))
    else $error("hold did not capture the high word");

  // ----
  // covers
  // ----
  cover property ($rose(o_irq));
  cover property (o_irq ##1 !o_irq);
  cover property (i_bus.rd && i_bus.addr == `EESF_OFS_HOLD);

endmodule : eesf_top_checker
`default_nettype wire

// ==== verif/eesf_encoder_model.sv ====
// encoder model: decoder count steps plus home and index pins
`timescale 1ns/1ps
`default_nettype none

module eesf_encoder_model (
  // clock
  input wire logic i_clk,
  // steps and pins
  output logic o_count_up,
  output logic o_count_down,
  output logic o_home,
  output logic o_index
);
  // pins idle low, always driven by the encoder
  initial
  begin
    o_count_up = 1'b0;
    o_count_down = 1'b0;
    o_home = 1'b0;
    o_index = 1'b0;
  end

  // one decoded step per cycle, back to back
  task automatic step(input int n, input logic dir_up);
    o_count_up <= dir_up;
    o_count_down <= !dir_up;
    repeat (n) @(posedge i_clk);
    o_count_up <= 1'b0;
    o_count_down <= 1'b0;
    @(posedge i_clk);
  endtask : step

  // held long enough to pass the two-flop synchroniser
  task automatic pulse(input logic is_home);
    if (is_home)
      o_home <= 1'b1;
    else
      o_index <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_home <= 1'b0;
    o_index <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : pulse

endmodule : eesf_encoder_model
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench of the encoder event status block
`timescale 1ns/1ps
`default_nettype none
`include "eesf_regs.svh"

module testbench;
  import eesf_pkg::*;
  logic i_clk;
  logic i_reset;
  eesf_bus_req_s bus;
  logic [15:0] rdata;
  logic up, dn, home, index, irq;
  logic [31:0] pos;
  logic [15:0] v;
  int mismatches;
  int check_count;

  eesf_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata), .i_count_up(up),
    .i_count_down(dn), .i_home(home), .i_index(index), .o_irq(irq), .o_position_count(pos));
  eesf_encoder_model enc (.i_clk(i_clk), .o_count_up(up), .o_count_down(dn), .o_home(home), .o_index(index));

  // ----
  // bus and compare tasks
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    @(negedge i_clk);
    d = rdata;
    @(posedge i_clk);
  endtask : rd

  task automatic rc(input string name, input logic [3:0] a, input logic [15:0] exp);
    rd(a, v);
    check(name, v, exp);
  endtask : rc

  // irq is registered, so give the flag path a few cycles
  task automatic irq_is(input logic e);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check("irq", {15'h0000, irq}, {15'h0000, e});
    @(posedge i_clk);
  endtask : irq_is

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    $display("run took too long");
    finish_test();
  end

  // ----
  // scenarios
  // ----
  initial
  begin
    i_reset = 1'b1;
    bus = '0;
    mismatches = 0;
    check_count = 0;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    // compares at zero are both true right after reset
    rc("stat", `EESF_OFS_STAT, 16'h2800);
    rc("mask", `EESF_OFS_MASK, 16'h007F);
    rc("pos_high", `EESF_OFS_POSH, 16'h0000);
    rc("mode", `EESF_OFS_CTRL, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rc("unmapped", 4'hF, 16'h0000);
    $display("reset and map test done");
    // all ones: reserved bits ignored, enables set, compare flags re-set
    wr(`EESF_OFS_STAT, 16'hFFFF);
    rc("stat", `EESF_OFS_STAT, 16'h3D55);
    irq_is(1'b1);
    wr(`EESF_OFS_GECL, 16'h0064);
    wr(`EESF_OFS_GECH, 16'h0000);
    wr(`EESF_OFS_LECL, 16'hFF9C);
    wr(`EESF_OFS_LECH, 16'hFFFF);
    wr(`EESF_OFS_STAT, 16'h2AAA);
    rc("stat", `EESF_OFS_STAT, 16'h0000);
    irq_is(1'b0);
    $display("enable and clear test done");
    // one below and at the upper compare value
    enc.step(99, 1'b1);
    repeat (4) @(posedge i_clk);
    rc("stat", `EESF_OFS_STAT, 16'h0000);
    enc.step(1, 1'b1);
    repeat (4) @(posedge i_clk);
    rc("stat", `EESF_OFS_STAT, 16'h2000);
    rc("pos_low", `EESF_OFS_POSL, 16'h0064);
    $display("compare test done");
    // signed wrap of the position counter
    wr(`EESF_OFS_HOLD, 16'h7FFF);
    wr(`EESF_OFS_POSL, 16'hFFFF);
    rc("pos_high", `EESF_OFS_POSH, 16'h7FFF);
    enc.step(1, 1'b1);
    repeat (4) @(posedge i_clk);
    rc("stat", `EESF_OFS_STAT, 16'h2A00);
    rc("pos_low", `EESF_OFS_POSL, 16'h0000);
    rc("hold", `EESF_OFS_HOLD, 16'h8000);
    rc("pos_high", `EESF_OFS_POSH, 16'h8000);
    // velocity wrap; lower compare stays true and re-sets
    wr(`EESF_OFS_STAT, 16'h2AAA);
    wr(`EESF_OFS_VEL, 16'h7FFF);
    enc.step(1, 1'b1);
    repeat (4) @(posedge i_clk);
    rc("stat", `EESF_OFS_STAT, 16'h0820);
    $display("overflow test done");
    // every init mode: home, one index, then a second index
    wr(`EESF_OFS_INITL, 16'h1234);
    wr(`EESF_OFS_INITH, 16'h0000);
    for (int m = 0; m < 5; m++)
    begin
      wr(`EESF_OFS_CTRL, m[15:0]);
      wr(`EESF_OFS_STAT, 16'h2AAA);
      enc.pulse(1'b1);
      enc.pulse(1'b0);
      rd(`EESF_OFS_STAT, v);
      check("first_index", v & 16'h008A, (m == 3) ? 16'h008A : 16'h000A);
      enc.pulse(1'b0);
      rd(`EESF_OFS_STAT, v);
      check("second_index", v & 16'h0080, (m == 3 || m == 4) ? 16'h0080 : 16'h0000);
    end
    rc("pos_low", `EESF_OFS_POSL, 16'h1234);
    rc("pos_high", `EESF_OFS_POSH, 16'h0000);
    check("pos_out", pos[15:0], 16'h1234);
    $display("homing test done");
    // home flag left set: enable, mask, unmask, clear
    wr(`EESF_OFS_STAT, 16'h0004);
    irq_is(1'b1);
    wr(`EESF_OFS_MASK, 16'h007D);
    irq_is(1'b0);
    wr(`EESF_OFS_MASK, 16'h007F);
    irq_is(1'b1);
    wr(`EESF_OFS_STAT, 16'h000C);
    irq_is(1'b0);
    rc("stat", `EESF_OFS_STAT, 16'h2086);
    $display("interrupt test done");
    finish_test();
  end

endmodule : testbench

bind eesf_top eesf_top_checker u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_count_up(i_count_up), .i_count_down(i_count_down), .i_home(i_home), .i_index(i_index),
  .o_irq(o_irq), .o_position_count(o_position_count));
`default_nettype wire
